// ==== design/usp_defines.svh ====
// constants for the spi-mode character transfer block
`ifndef USP_DEFINES_SVH
`define USP_DEFINES_SVH
`define USP_CLK_NS 40
`define USP_TBIT_NS 320
`define USP_BIT_CYC ((`USP_TBIT_NS + `USP_CLK_NS - 1) / `USP_CLK_NS)
`define USP_CHAR_BITS 8
`define USP_LEAD_BITS 1
`define USP_TRAIL_BITS 1
`define USP_GAP_BITS 3
`define USP_LINE_IDLE 1'b1
`define USP_SHIFT_RST 8'hFF
`define USP_HOLD_RST 8'h00
`endif

// ==== design/usp_pkg.sv ====
// types for the spi-mode character transfer block
package usp_pkg;
  typedef enum logic [2:0] {
    USP_IDLE = 3'b000,
    USP_LEAD = 3'b001,
    USP_SHIFT = 3'b010,
    USP_TRAIL = 3'b011,
    USP_GAP = 3'b100
  } usp_state_t;
endpackage

// ==== design/usp_spi_xfer.sv ====
// spi master/slave character transmit and receive with status flags
`timescale 1ns/1ps
`default_nettype none
`include "usp_defines.svh"

module usp_spi_xfer #(
  parameter int BIT_CYC = `USP_BIT_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sck,
  input wire logic i_master_mode,
  input wire logic i_tx_enable,
  input wire logic i_wait_read_before_transmit,
  input wire logic i_tx_write,
  input wire logic [7:0] i_tx_data,
  input wire logic i_rx_read,
  input wire logic i_clear_status_cmd,
  input wire logic i_force_select_low_cmd,
  input wire logic i_release_select_cmd,
  input wire logic i_rxd,
  input wire logic i_slave_select_n,
  output logic o_txd,
  output logic o_sck,
  output logic o_slave_select_n,
  output logic [7:0] o_rx_data,
  output logic o_tx_holding_empty,
  output logic o_tx_all_done,
  output logic o_rx_char_available,
  output logic o_rx_overrun,
  output logic o_tx_underrun,
  output logic o_rx_timeout
);
  localparam int CW = $clog2(BIT_CYC);
  localparam int HALF = BIT_CYC / 2;

  if (BIT_CYC < 2 || (BIT_CYC % 2) != 0) begin : g_chk
    $error("BIT_CYC must be even and at least 2");
  end

  typedef struct packed {
    usp_pkg::usp_state_t st;
    logic [CW-1:0] cnt;
    logic [2:0] bits;
    logic [7:0] sh;
    logic [7:0] rsh;
    logic sck;
    logic sel_n;
    logic forced;
    logic [7:0] thr;
    logic thr_full;
    logic [7:0] xdata;
    logic req_t;
    logic ack_s1;
    logic ack_s2;
    logic rx_s1;
    logic rx_s2;
    logic rx_d;
    logic un_s1;
    logic un_s2;
    logic un_d;
    logic rxd_s1;
    logic rxd_s2;
    logic [7:0] rhr;
    logic rx_avail;
    logic rx_overrun_flag;
    logic tx_underrun_flag;
  } usp_core_t;

  // link side, kept across frames: toggles and received byte
  typedef struct packed {
    logic rq_s1;
    logic rq_s2;
    logic ack_t;
    logic rx_t;
    logic un_t;
    logic [7:0] rx_byte;
  } usp_link_t;

  // link side, cleared whenever select is high
  typedef struct packed {
    logic [2:0] cnt;
    logic [7:0] tx_sh;
    logic [6:0] rx_sh;
    logic tx_underrun_flag;
  } usp_frame_t;

  usp_core_t c, cn;
  usp_link_t p, pn;
  usp_frame_t f, fn;
  logic frm_rst_n;
  logic take;
  logic bit_end;
  logic rx_done_m;
  logic rx_done_s;
  logic un_ev;
  logic allow;
  logic pending;
  logic slave_txd;

  // core domain
  always_comb begin
    cn = c;
    bit_end = c.cnt == CW'(BIT_CYC - 1);
    rx_done_m = 1'b0;
    rx_done_s = c.rx_s2 != c.rx_d;
    un_ev = c.un_s2 != c.un_d;
    allow = !i_wait_read_before_transmit || !c.rx_avail;
    pending = c.req_t != c.ack_s2;
    cn.ack_s1 = p.ack_t;
    cn.ack_s2 = c.ack_s1;
    cn.rx_s1 = p.rx_t;
    cn.rx_s2 = c.rx_s1;
    cn.rx_d = c.rx_s2;
    cn.un_s1 = p.un_t;
    cn.un_s2 = c.un_s1;
    cn.un_d = c.un_s2;
    cn.rxd_s1 = i_rxd;
    cn.rxd_s2 = c.rxd_s1;
    if (i_tx_write && i_tx_enable && !c.thr_full) begin
      cn.thr = i_tx_data;
      cn.thr_full = 1'b1;
    end
    if (!i_master_mode && i_tx_enable && c.thr_full && allow && !pending) begin
      cn.xdata = c.thr;
      cn.thr_full = 1'b0;
      cn.req_t = !c.req_t;
    end
    if (c.st != usp_pkg::USP_IDLE) begin
      cn.cnt = bit_end ? '0 : c.cnt + 1'b1;
    end
    case (c.st)
      usp_pkg::USP_IDLE: begin
        cn.cnt = '0;
        if (i_master_mode && i_tx_enable && c.thr_full && allow) begin
          cn.sh = c.thr;
          cn.thr_full = 1'b0;
          cn.st = usp_pkg::USP_LEAD;
          cn.bits = '0;
        end
      end
      usp_pkg::USP_LEAD: begin
        if (bit_end && c.bits == 3'(`USP_LEAD_BITS - 1)) begin
          cn.st = usp_pkg::USP_SHIFT;
          cn.bits = '0;
        end else if (bit_end) begin
          cn.bits = c.bits + 1'b1;
        end
      end
      usp_pkg::USP_SHIFT: begin
        if (c.cnt == CW'(HALF - 1)) begin
          cn.rsh = {c.rsh[6:0], c.rxd_s2};
        end
        if (bit_end) begin
          cn.sh = {c.sh[6:0], `USP_LINE_IDLE};
          cn.bits = c.bits + 1'b1;
          if (c.bits == 3'(`USP_CHAR_BITS - 1)) begin
            cn.st = usp_pkg::USP_TRAIL;
            cn.bits = '0;
          end
        end
      end
      usp_pkg::USP_TRAIL: begin
        if (bit_end && c.bits == 3'(`USP_TRAIL_BITS - 1)) begin
          rx_done_m = 1'b1;
          cn.st = usp_pkg::USP_GAP;
          cn.bits = '0;
        end else if (bit_end) begin
          cn.bits = c.bits + 1'b1;
        end
      end
      usp_pkg::USP_GAP: begin
        if (bit_end) begin
          cn.bits = c.bits + 1'b1;
          if (c.bits == 3'(`USP_GAP_BITS - 1)) begin
            cn.st = usp_pkg::USP_IDLE;
          end
        end
      end
      default: begin
        cn.st = usp_pkg::USP_IDLE;
      end
    endcase
    cn.sck = cn.st == usp_pkg::USP_SHIFT && cn.cnt >= CW'(HALF);
    // release wins if both commands arrive together
    if (i_release_select_cmd) begin
      cn.forced = 1'b0;
    end else if (i_force_select_low_cmd) begin
      cn.forced = 1'b1;
    end
    cn.sel_n = !(cn.forced || cn.st == usp_pkg::USP_LEAD || cn.st == usp_pkg::USP_SHIFT
                 || cn.st == usp_pkg::USP_TRAIL);
    if (i_rx_read) begin
      cn.rx_avail = 1'b0;
    end
    if (i_clear_status_cmd) begin
      cn.rx_overrun_flag = 1'b0;
      cn.tx_underrun_flag = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (rx_done_m || rx_done_s) begin
      cn.rhr = rx_done_m ? c.rsh : p.rx_byte;
      cn.rx_avail = 1'b1;
      if (c.rx_avail) begin
        cn.rx_overrun_flag = 1'b1;
      end
    end
    if (un_ev) begin
      cn.tx_underrun_flag = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      c <= '0;
      c.st <= usp_pkg::USP_IDLE;
      c.sh <= `USP_SHIFT_RST;
      c.thr <= `USP_HOLD_RST;
      c.sel_n <= 1'b1;
    end else begin
      c <= cn;
    end
  end

  // link domain; frame logic is reset by select high, so no edge is needed
  assign frm_rst_n = i_rst_n && i_slave_select_n == 1'b0 && !i_master_mode;
  assign take = p.rq_s2 != p.ack_t;

  always_comb begin
    pn = p;
    fn = f;
    pn.rq_s1 = c.req_t;
    pn.rq_s2 = p.rq_s1;
    fn.cnt = f.cnt + 1'b1;
    fn.rx_sh = {f.rx_sh[5:0], i_rxd};
    fn.tx_sh = {f.tx_sh[6:0], `USP_LINE_IDLE};
    if (f.cnt == 3'h0) begin
      fn.tx_underrun_flag = !take;
      fn.tx_sh = take ? {c.xdata[6:0], `USP_LINE_IDLE} : `USP_SHIFT_RST;
      if (take) begin
        pn.ack_t = !p.ack_t;
      end else begin
        pn.un_t = !p.un_t;
      end
    end
    if (f.cnt == 3'(`USP_CHAR_BITS - 1)) begin
      pn.rx_byte = {f.rx_sh, i_rxd};
      pn.rx_t = !p.rx_t;
    end
  end

  always_ff @(posedge i_sck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      p <= '0;
    end else begin
      p <= pn;
    end
  end

  always_ff @(posedge i_sck or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      f <= '0;
      f.tx_sh <= `USP_SHIFT_RST;
    end else begin
      f <= fn;
    end
  end

  // first bit is presented before the first clock edge of the character
  always_comb begin
    if (f.cnt == 3'h0) begin
      slave_txd = take ? c.xdata[7] : `USP_LINE_IDLE;
    end else begin
      slave_txd = f.tx_underrun_flag ? `USP_LINE_IDLE : f.tx_sh[7];
    end
  end

  assign o_txd = i_master_mode ? c.sh[7] : slave_txd;
  assign o_sck = c.sck;
  assign o_slave_select_n = c.sel_n;
  assign o_rx_data = c.rhr;
  assign o_tx_holding_empty = i_tx_enable && !c.thr_full;
  assign o_tx_all_done = i_tx_enable && !c.thr_full && c.st == usp_pkg::USP_IDLE && !pending;
  assign o_rx_char_available = c.rx_avail;
  assign o_rx_overrun = c.rx_overrun_flag;
  assign o_tx_underrun = c.tx_underrun_flag;
  assign o_rx_timeout = 1'b0;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  wait_read_a: assert property (i_master_mode && i_wait_read_before_transmit && c.rx_avail
    && c.st == usp_pkg::USP_IDLE |=> c.st == usp_pkg::USP_IDLE)
    else $error("transmit started with unread receive data");
  move_hold_a: assert property (c.st == usp_pkg::USP_IDLE && i_master_mode && i_tx_enable && c.thr_full
    && allow |=> !c.thr_full && c.st == usp_pkg::USP_LEAD && o_tx_holding_empty)
    else $error("holding register not moved to shifter");
  all_done_a: assert property (o_tx_all_done |-> !c.thr_full && c.st == usp_pkg::USP_IDLE)
    else $error("all-done with work outstanding");
  tx_disabled_a: assert property (!i_tx_enable |-> !o_tx_holding_empty && !o_tx_all_done)
    else $error("tx flags high while disabled");
  write_drop_a: assert property (i_tx_write && c.thr_full |=> $stable(c.thr))
    else $error("write accepted while holding full");
  underrun_set_a: assert property (un_ev |=> o_tx_underrun)
    else $error("underrun not flagged");
  status_clear_a: assert property (i_clear_status_cmd && !un_ev && !rx_done_m && !rx_done_s
    |=> !o_tx_underrun && !o_rx_overrun)
    else $error("clear-status did not clear errors");
  select_lead_a: assert property ($rose(c.st == usp_pkg::USP_LEAD) |-> !o_slave_select_n && !o_sck
    ##1 (c.st == usp_pkg::USP_LEAD && !o_slave_select_n) [*1])
    else $error("select not low before first bit");
  gap_high_a: assert property (c.st == usp_pkg::USP_GAP && !c.forced |-> o_slave_select_n)
    else $error("select low during gap");
  select_hold_a: assert property (c.forced && !i_release_select_cmd |=> !o_slave_select_n)
    else $error("forced select released without command");
  rx_store_a: assert property (rx_done_m |=> o_rx_char_available && o_rx_data == $past(c.rsh))
    else $error("received character not stored");
  overrun_set_a: assert property ((rx_done_m || rx_done_s) && c.rx_avail |=> o_rx_overrun)
    else $error("overrun not flagged");
  no_timeout_a: assert property (##1 !o_rx_timeout)
    else $error("timeout raised in spi mode");
endmodule // usp_spi_xfer
`default_nettype wire

// ==== dv/usp_far_end.sv ====
// far-end spi partner: master for slave mode, responder for master mode
`timescale 1ns/1ps
`default_nettype none
module usp_far_end (
  input wire logic i_master_mode,
  input wire logic i_sck_in,
  input wire logic i_ss_n_in,
  input wire logic i_miso,
  output logic o_sck,
  output logic o_ss_n,
  output logic o_mosi
);
  logic [7:0] reply = 8'h3C;
  logic [7:0] got = 8'h00;
  logic [7:0] sh = 8'h00;
  int frames = 0;
  int nb = 0;
  initial begin
    o_sck = 1'b0;
    o_ss_n = 1'b1;
    o_mosi = 1'b1;
  end
  always @(negedge i_ss_n_in) if (i_master_mode) begin
    sh = reply;
    nb = 0;
    o_mosi = sh[7];
  end
  always @(posedge i_sck_in) if (i_master_mode) begin
    got = {got[6:0], i_miso};
    nb++;
    if (nb == 8) begin
      frames++;
      nb = 0;
    end
  end
  // change after the falling edge so data stays put across the sync flops
  always @(negedge i_sck_in) if (i_master_mode) begin
    if (nb == 0) sh = reply;
    else sh = {sh[6:0], ~sh[7]};
    o_mosi = sh[7];
  end
  always @(posedge i_ss_n_in) if (i_master_mode) o_mosi = ~o_mosi;
  // clock stands still between frames; released data line shows the inverse
  task automatic frame(input logic [7:0] b);
    #13;
    o_ss_n = 1'b0;
    #125;
    for (int i = 7; i >= 0; i--) begin
      o_mosi = b[i];
      #62.5;
      got = {got[6:0], i_miso};
      o_sck = 1'b1;
      #62.5;
      o_sck = 1'b0;
    end
    frames++;
    o_ss_n = 1'b1;
    o_mosi = ~o_mosi;
    #250;
  endtask
endmodule // usp_far_end
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench for the spi-mode character transfer block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_master_mode = 1'b1;
  logic i_tx_enable = 1'b0;
  logic i_wait_read_before_transmit = 1'b0;
  logic i_tx_write = 1'b0;
  logic [7:0] i_tx_data = 8'h00;
  logic i_rx_read = 1'b0;
  logic i_clear_status_cmd = 1'b0;
  logic i_force_select_low_cmd = 1'b0;
  logic i_release_select_cmd = 1'b0;
  logic i_sck, i_rxd, i_slave_select_n, o_txd, o_sck, o_slave_select_n;
  logic o_tx_holding_empty, o_tx_all_done, o_rx_char_available, o_rx_overrun, o_tx_underrun, o_rx_timeout;
  logic [7:0] o_rx_data;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  realtime t0;
  always #20 i_clk = ~i_clk;
  usp_spi_xfer #(.BIT_CYC(8)) i_dut (.i_clk, .i_rst_n, .i_sck, .i_master_mode, .i_tx_enable,
    .i_wait_read_before_transmit, .i_tx_write, .i_tx_data, .i_rx_read, .i_clear_status_cmd,
    .i_force_select_low_cmd, .i_release_select_cmd, .i_rxd, .i_slave_select_n, .o_txd, .o_sck,
    .o_slave_select_n, .o_rx_data, .o_tx_holding_empty, .o_tx_all_done, .o_rx_char_available,
    .o_rx_overrun, .o_tx_underrun, .o_rx_timeout);
  usp_far_end i_far (.i_master_mode, .i_sck_in(o_sck), .i_ss_n_in(o_slave_select_n), .i_miso(o_txd),
    .o_sck(i_sck), .o_ss_n(i_slave_select_n), .o_mosi(i_rxd));
  task automatic test_done;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic write(input logic [7:0] d);
    i_tx_data = d;
    pulse(i_tx_write);
  endtask
  // the global cycle ceiling bounds this wait
  task automatic wait_done;
    while (o_tx_all_done !== 1'b1) tick(1);
  endtask
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done;
    end
  end
  initial begin
    tick(12);
    i_rst_n = 1'b1;
    chk({o_slave_select_n, o_tx_holding_empty, o_tx_all_done, o_rx_char_available, o_rx_overrun,
      o_tx_underrun, o_rx_timeout, 1'b0}, 8'h80);
    i_tx_enable = 1'b1;
    tick(1);
    chk({6'h00, o_tx_holding_empty, o_tx_all_done}, 8'h03);
    // strobe held over two edges: the second write meets a full holding register
    i_tx_data = 8'hA5;
    i_tx_write = 1'b1;
    tick(1);
    chk({7'h00, o_tx_holding_empty}, 8'h00);
    i_tx_data = 8'h5A;
    tick(1);
    i_tx_write = 1'b0;
    chk({7'h00, o_tx_holding_empty}, 8'h01);
    chk({7'h00, o_slave_select_n}, 8'h00);
    t0 = $realtime - 1.0;
    @(posedge o_sck);
    chk(8'(int'(($realtime - t0) / 40)), 8'h0C);
    wait_done;
    chk(i_far.got, 8'hA5);
    chk(8'(i_far.frames), 8'h01);
    chk(o_rx_data, 8'h3C);
    chk({7'h00, o_rx_char_available}, 8'h01);
    i_far.reply = 8'h96;
    write(8'h11);
    wait_done;
    chk({7'h00, o_rx_overrun}, 8'h01);
    chk(o_rx_data, 8'h96);
    pulse(i_clear_status_cmd);
    chk({7'h00, o_rx_overrun}, 8'h00);
    i_wait_read_before_transmit = 1'b1;
    write(8'h33);
    tick(200);
    chk(8'(i_far.frames), 8'h02);
    pulse(i_rx_read);
    chk({7'h00, o_rx_char_available}, 8'h00);
    wait_done;
    chk(i_far.got, 8'h33);
    i_wait_read_before_transmit = 1'b0;
    write(8'h01);
    // holding register frees one edge after the first write is taken
    tick(1);
    write(8'h02);
    @(posedge o_slave_select_n);
    t0 = $realtime;
    @(negedge o_slave_select_n);
    chk({7'h00, ($realtime - t0) >= 960.0}, 8'h01);
    wait_done;
    tick(1);
    pulse(i_force_select_low_cmd);
    write(8'h44);
    wait_done;
    tick(30);
    chk({7'h00, o_slave_select_n}, 8'h00);
    pulse(i_release_select_cmd);
    tick(1);
    chk({7'h00, o_slave_select_n}, 8'h01);
    i_master_mode = 1'b0;
    pulse(i_clear_status_cmd);
    pulse(i_rx_read);
    i_far.frame(8'hC3);
    tick(5);
    chk(i_far.got, 8'hFF);
    chk({7'h00, o_tx_underrun}, 8'h01);
    chk(o_rx_data, 8'hC3);
    pulse(i_clear_status_cmd);
    chk({7'h00, o_tx_underrun}, 8'h00);
    write(8'hB7);
    i_far.frame(8'h5A);
    i_far.frame(8'h69);
    tick(5);
    chk(i_far.got, 8'hB7);
    chk(o_rx_data, 8'h69);
    test_done;
  end
endmodule // testbench
`default_nettype wire
